// file: rtl/charge_cycle_sequencer.sv
`timescale 1ns/1ps
`include "charge_cycle_map.svh"
module charge_cycle_sequencer #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Mode controls
  input wire logic i_mode_select_one,
  input wire logic i_mode_select_two,
  input wire logic i_emulation_enable,
  input wire logic i_port_power_enable,
  // Analog measurements
  input wire logic [7:0] i_port_current,
  input wire charge_cycle_pkg::limit_code_t i_current_limit_setting,
  // Register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // Port controls
  output logic o_power_switch_close,
  output logic o_discharge_en,
  output logic o_data_pulldown_en,
  output logic [8:0] o_profile_drive,
  output logic o_hs_switch_close,
  output logic o_cc_limit,
  output logic o_no_handshake_flag
);
  import charge_cycle_pkg::*;

  seq_state_t state_q;
  seq_state_t state_d;
  logic [3:0] pos_q;
  logic [3:0] pos_d;
  logic [7:0] emu_cfg_q;
  logic [7:0] prof_en_q;
  logic [7:0] threshold_q;
  logic [7:0] hs_cfg_q;
  logic [7:0] custom_cfg_q;
  logic [7:0] ccl_cfg_q;
  logic [7:0] timeout_q [0:8];
  logic [2:0] mode_q;
  logic no_handshake_flag_q;
  logic accepted_q;
  logic start_d;
  logic [7:0] load_d;
  logic dedicated_charge_cycle;
  logic mode_changed;
  logic [8:0] enabled;
  logic [3:0] prof;
  logic timeout_en;
  logic current_limit_setting_low;
  logic region_cc;
  logic cc_d;
  logic hs_d;
  logic [8:0] drive_d;
  tick_timer_if tmr ();

  tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .tmr(tmr)
  );

  // ****************************************
  // Sequence position helpers
  // ****************************************
  function automatic logic [3:0] pos_to_prof(input logic [3:0] p, input logic first);
    if (first) begin
      pos_to_prof = (p == 4'h0) ? `PROF_CUSTOM : p - 4'h1; // [R8]
    end else begin
      pos_to_prof = p; // [R7]
    end
  endfunction

  function automatic logic [3:0] next_pos(input logic [3:0] from, input logic [8:0] en, input logic first);
    logic [3:0] found;
    found = `POS_NONE;
    for (int i = 8; i >= 0; i--) begin
      if (4'(i) >= from && en[pos_to_prof(4'(i), first)]) begin
        found = 4'(i); // [R7]
      end
    end
    next_pos = found;
  endfunction

  assign dedicated_charge_cycle = i_emulation_enable && !i_mode_select_two; // [R21]
  assign mode_changed = mode_q != {i_mode_select_one, i_mode_select_two, i_emulation_enable};
  assign enabled = {custom_cfg_q[`CUSTOM_ENABLE_BIT], prof_en_q};
  assign prof = pos_to_prof(pos_q, custom_cfg_q[`CUSTOM_FIRST_BIT]);
  assign timeout_en = (prof == `PROF_CUSTOM) ? custom_cfg_q[`CUSTOM_TIMEOUT_EN_BIT] : emu_cfg_q[`EMU_TIMEOUT_EN_BIT];
  assign tmr.start = start_d;
  assign tmr.load = load_d;

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      emu_cfg_q <= `EMULATION_CONFIGURATION_RST; // [R10] [R12]
      prof_en_q <= `PROFILE_ENABLE_RST;
      threshold_q <= `CHARGE_THRESHOLD_RST;
      hs_cfg_q <= `HIGH_SPEED_SWITCH_CONFIG_RST;
      custom_cfg_q <= `CUSTOM_EMULATION_CONFIG_RST; // [R7]
      ccl_cfg_q <= `CUSTOM_CURRENT_LIMIT_CONFIG_RST;
      for (int i = 0; i < `NUM_PROFILES; i++) begin
        timeout_q[i] <= `TIMEOUT_RST;
      end
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `REG_EMULATION_CONFIGURATION: emu_cfg_q <= i_reg_wdata;
        `REG_PROFILE_ENABLE: prof_en_q <= i_reg_wdata;
        `REG_CHARGE_THRESHOLD: threshold_q <= i_reg_wdata;
        `REG_HIGH_SPEED_SWITCH_CONFIG: hs_cfg_q <= i_reg_wdata;
        `REG_CUSTOM_EMULATION_CONFIG: custom_cfg_q <= i_reg_wdata;
        `REG_CUSTOM_TIMEOUT: timeout_q[8] <= i_reg_wdata; // [R11]
        `REG_CUSTOM_CURRENT_LIMIT_CONFIG: ccl_cfg_q <= i_reg_wdata;
        default: begin
          if (i_reg_addr[7:3] == 5'(`REG_PRELOAD_TIMEOUT_BASE >> 3)) begin
            timeout_q[i_reg_addr[2:0]] <= i_reg_wdata; // [R11]
          end
        end
      endcase
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `REG_PROFILE_STATUS_ONE: o_reg_rdata <= {accepted_q ? prof : 4'h0, 2'h0, accepted_q, no_handshake_flag_q};
        `REG_EMULATION_CONFIGURATION: o_reg_rdata <= emu_cfg_q;
        `REG_PROFILE_ENABLE: o_reg_rdata <= prof_en_q;
        `REG_CHARGE_THRESHOLD: o_reg_rdata <= threshold_q;
        `REG_HIGH_SPEED_SWITCH_CONFIG: o_reg_rdata <= hs_cfg_q;
        `REG_CUSTOM_EMULATION_CONFIG: o_reg_rdata <= custom_cfg_q;
        `REG_CUSTOM_TIMEOUT: o_reg_rdata <= timeout_q[8];
        `REG_CUSTOM_CURRENT_LIMIT_CONFIG: o_reg_rdata <= ccl_cfg_q;
        default: begin
          if (i_reg_addr[7:3] == 5'(`REG_PRELOAD_TIMEOUT_BASE >> 3)) begin
            o_reg_rdata <= timeout_q[i_reg_addr[2:0]];
          end else begin
            o_reg_rdata <= 8'h00;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Sequencer next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    pos_d = pos_q;
    start_d = 1'b0;
    load_d = 8'h00;
    if (!i_port_power_enable || !dedicated_charge_cycle || mode_changed) begin
      state_d = ST_IDLE; // [R23] [R24]
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_DISCHARGE; // [R4]
          pos_d = next_pos(4'h0, enabled, custom_cfg_q[`CUSTOM_FIRST_BIT]);
          start_d = 1'b1;
          load_d = `DISCHARGE_TICKS;
        end
        ST_DISCHARGE: begin
          if (tmr.expired) begin
            state_d = ST_HOLD; // [R5]
            start_d = 1'b1;
            load_d = `RESET_HOLD_TICKS;
          end
        end
        ST_HOLD: begin
          if (tmr.expired) begin
            if (pos_q != `POS_NONE) begin
              state_d = ST_APPLY;
              start_d = timeout_en; // [R1]
              load_d = timeout_q[prof]; // [R11]
            end else if (emu_cfg_q[`EMU_RETRY_BIT]) begin
              state_d = ST_DISCHARGE; // [R12]
              pos_d = next_pos(4'h0, enabled, custom_cfg_q[`CUSTOM_FIRST_BIT]);
              start_d = 1'b1;
              load_d = `DISCHARGE_TICKS;
            end else begin
              state_d = ST_NO_HANDSHAKE_FLAG; // [R13]
            end
          end
        end
        ST_APPLY: begin
          if (tmr.expired) begin
            if (i_port_current > threshold_q) begin
              state_d = ST_ACCEPTED; // [R2] [R9]
            end else begin
              pos_d = next_pos(pos_q + 4'h1, enabled, custom_cfg_q[`CUSTOM_FIRST_BIT]); // [R10]
              if (pos_d == `POS_NONE && !emu_cfg_q[`EMU_RETRY_BIT]) begin
                state_d = ST_NO_HANDSHAKE_FLAG; // [R13]
              end else begin
                if (pos_d == `POS_NONE) begin
                  pos_d = next_pos(4'h0, enabled, custom_cfg_q[`CUSTOM_FIRST_BIT]); // [R12]
                end
                state_d = ST_DISCHARGE; // [R10]
                start_d = 1'b1;
                load_d = `DISCHARGE_TICKS;
              end
            end
          end
        end
        ST_ACCEPTED: state_d = ST_ACCEPTED; // [R23]
        ST_NO_HANDSHAKE_FLAG: state_d = ST_NO_HANDSHAKE_FLAG;
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      pos_q <= 4'h0;
      mode_q <= 3'h0;
    end else begin
      state_q <= state_d;
      pos_q <= pos_d;
      mode_q <= {i_mode_select_one, i_mode_select_two, i_emulation_enable};
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      no_handshake_flag_q <= 1'b0;
      accepted_q <= 1'b0;
    end else begin
      if (state_d == ST_NO_HANDSHAKE_FLAG) begin
        no_handshake_flag_q <= 1'b1; // [R14]
      end else if (state_d == ST_DISCHARGE && state_q == ST_IDLE) begin
        no_handshake_flag_q <= 1'b0;
      end
      accepted_q <= state_d == ST_ACCEPTED;
    end
  end

  // ****************************************
  // Current limit, switch and line drive
  // ****************************************
  always_comb begin
    current_limit_setting_low = i_current_limit_setting <= `CURRENT_LIMIT_SETTING_1P5_CODE;
    region_cc = current_limit_setting_low && !(ccl_cfg_q[`R2MIN_MSB:`R2MIN_LSB] <= i_current_limit_setting); // [R20] [R18]
    cc_d = 1'b0;
    hs_d = 1'b1;
    drive_d = 9'h000;
    if (!dedicated_charge_cycle) begin
      cc_d = i_emulation_enable && current_limit_setting_low; // [R19]
      hs_d = !(i_emulation_enable && !i_mode_select_one);
    end else begin
      hs_d = hs_cfg_q[`HS_CLOSE_CHARGING_BIT]; // [R3]
      case (state_q)
        ST_APPLY, ST_ACCEPTED: begin
          if (state_q == ST_APPLY && timeout_en) begin
            cc_d = current_limit_setting_low; // [R16]
          end else if (prof == `PROF_DCP || prof == `PROF_LEGACY2) begin
            cc_d = current_limit_setting_low; // [R17]
          end else begin
            cc_d = region_cc; // [R18]
          end
          drive_d[prof] = 1'b1;
          if (state_q == ST_ACCEPTED && !emu_cfg_q[`EMU_KEEP_RESPONSE_BIT] && prof != `PROF_DCP
              && prof != `PROF_LEGACY2 && prof != `PROF_CUSTOM) begin
            drive_d = 9'h000; // [R22]
          end
        end
        ST_NO_HANDSHAKE_FLAG: begin
          cc_d = region_cc; // [R18]
          hs_d = hs_cfg_q[`HS_CLOSE_NO_HANDSHAKE_FLAG_BIT]; // [R15]
        end
        default: cc_d = current_limit_setting_low;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_power_switch_close <= 1'b0;
      o_discharge_en <= 1'b0;
      o_data_pulldown_en <= 1'b0;
      o_profile_drive <= 9'h000;
      o_hs_switch_close <= 1'b0;
      o_cc_limit <= 1'b0;
      o_no_handshake_flag <= 1'b0;
    end else begin
      o_power_switch_close <= i_port_power_enable && state_q != ST_DISCHARGE && state_q != ST_HOLD; // [R5] [R19]
      o_discharge_en <= state_q == ST_DISCHARGE; // [R4]
      o_data_pulldown_en <= state_q == ST_DISCHARGE || state_q == ST_HOLD; // [R6]
      o_profile_drive <= i_port_power_enable ? drive_d : 9'h000; // [R15] [R24]
      o_hs_switch_close <= hs_d;
      o_cc_limit <= cc_d;
      o_no_handshake_flag <= no_handshake_flag_q; // [R14]
    end
  end
endmodule

// file: rtl/charge_cycle_map.svh
// Notes on behaviour
// R1: Start the profile timer when a profile begins.
// R2: At expiry, current above threshold accepts profile.
// R3: Data switch open while charging, unless configured.
// R4: Emulation reset: switch open, supply discharged.
// R5: Switch held open, then closed again.
// R6: Data line pull-downs on during emulation reset.
// R7: Enabled profiles in fixed order; custom off.
// R8: Custom-first bit moves custom to the front.
// R9: Accepted profile ends the sequence.
// R10: Timeout without current: reject, reset, next.
// R11: Each profile has its own timeout value.
// R12: All rejected with retry: reset and restart.
// R13: All rejected without retry: no-handshake, stop.
// R14: No-handshake flag set and stays set.
// R15: No-handshake removes signatures; switch per config.
// R16: While timing: constant current if limit low.
// R17: DCP, Legacy 2 or untimed: same limit choice; code: other untimed profiles use region_cc.
// R18: Other accepted or no-handshake: region-two compare.
// R19: Outside the cycle: switch closed, mode limits.
// R20: Region-two minimum from bits 4..2 at 51h.
// R21: Mode from two select bits and emulation enable.
// R22: Accepted legacy voltages stay unless keep bit 0.
// R23: Accepted profile held until mode or power change.
// R24: Power enable low aborts the cycle.
`ifndef CHARGE_CYCLE_MAP_SVH
`define CHARGE_CYCLE_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_PROFILE_STATUS_ONE 8'h12
`define REG_EMULATION_CONFIGURATION 8'h16
`define REG_PROFILE_ENABLE 8'h17
`define REG_CHARGE_THRESHOLD 8'h18
`define REG_HIGH_SPEED_SWITCH_CONFIG 8'h25
`define REG_PRELOAD_TIMEOUT_BASE 8'h30
`define REG_CUSTOM_EMULATION_CONFIG 8'h40
`define REG_CUSTOM_TIMEOUT 8'h41
`define REG_CUSTOM_CURRENT_LIMIT_CONFIG 8'h51

// ****************************************
// Field positions
// ****************************************
`define EMU_TIMEOUT_EN_BIT 0
`define EMU_RETRY_BIT 1
`define EMU_KEEP_RESPONSE_BIT 2
`define CUSTOM_ENABLE_BIT 0
`define CUSTOM_FIRST_BIT 1
`define CUSTOM_TIMEOUT_EN_BIT 2
`define HS_CLOSE_CHARGING_BIT 0
`define HS_CLOSE_NO_HANDSHAKE_FLAG_BIT 1
`define R2MIN_MSB 4
`define R2MIN_LSB 2
`define STATUS_NO_HANDSHAKE_FLAG_BIT 0
`define STATUS_ACCEPTED_BIT 1

// ****************************************
// Reset values
// ****************************************
`define EMULATION_CONFIGURATION_RST 8'h07
`define PROFILE_ENABLE_RST 8'hff
`define CHARGE_THRESHOLD_RST 8'h10
`define HIGH_SPEED_SWITCH_CONFIG_RST 8'h00
`define CUSTOM_EMULATION_CONFIG_RST 8'h04
`define TIMEOUT_RST 8'h0a
`define CUSTOM_CURRENT_LIMIT_CONFIG_RST 8'h00

// ****************************************
// Profiles, limits and timing
// ****************************************
`define NUM_PROFILES 9
`define PROF_LEGACY1 4'h0
`define PROF_DCP 4'h1
`define PROF_LEGACY2 4'h2
`define PROF_CUSTOM 4'h8
`define POS_NONE 4'h9
`define CURRENT_LIMIT_SETTING_1P5_CODE 3'h3
`define CLK_PERIOD_NS 4
`define TICK_TIME_NS 1000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define DISCHARGE_TICKS 8'h05
`define RESET_HOLD_TICKS 8'h0a

`endif

// file: rtl/charge_cycle_pkg.sv
package charge_cycle_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DISCHARGE = 6'h02,
    ST_HOLD = 6'h04,
    ST_APPLY = 6'h08,
    ST_ACCEPTED = 6'h10,
    ST_NO_HANDSHAKE_FLAG = 6'h20
  } seq_state_t;
  typedef logic [2:0] limit_code_t;
endpackage

// file: rtl/tick_timer_if.sv
`timescale 1ns/1ps
interface tick_timer_if;
  logic start;
  logic [7:0] load;
  logic expired;
  modport owner (output start, output load, input expired);
  modport timer (input start, input load, output expired);
endinterface

// file: rtl/tick_timer.sv
`timescale 1ns/1ps
module tick_timer #(
  parameter int TICK_CYCLES = 250000
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Control
  tick_timer_if.timer tmr
);
  logic [31:0] pre_q;
  logic [7:0] ticks_q;
  logic run_q;

  // ****************************************
  // Prescaler and tick countdown
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pre_q <= 32'h0;
      ticks_q <= 8'h0;
      run_q <= 1'b0;
      tmr.expired <= 1'b0;
    end else begin
      tmr.expired <= 1'b0;
      if (tmr.start) begin
        pre_q <= 32'h0;
        ticks_q <= (tmr.load == 8'h0) ? 8'h1 : tmr.load;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (pre_q == 32'(TICK_CYCLES - 1)) begin
          pre_q <= 32'h0;
          if (ticks_q == 8'h1) begin
            run_q <= 1'b0;
            tmr.expired <= 1'b1;
          end
          ticks_q <= ticks_q - 8'h1;
        end else begin
          pre_q <= pre_q + 32'h1;
        end
      end
    end
  end
endmodule

// file: bench/portable_device_model.sv
`timescale 1ns/1ps
module portable_device_model (
  // Port side
  input wire logic i_switch_close,
  input wire logic [8:0] i_drive,
  // Profiles this device answers to
  input wire logic [8:0] i_accept_mask,
  // Measured draw
  output logic [7:0] o_current
);
  // ****************************************
  // Charge draw
  // ****************************************
  // Draws well above threshold only on a matching signature
  assign o_current = (i_switch_close && (|(i_drive & i_accept_mask))) ? 8'h40 : 8'h00;
endmodule

// file: bench/charge_cycle_sequencer_chk.sv
`timescale 1ns/1ps
`include "charge_cycle_map.svh"
module charge_cycle_sequencer_chk #(
  parameter int TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Mode controls
  input wire logic i_mode_select_one,
  input wire logic i_mode_select_two,
  input wire logic i_emulation_enable,
  input wire logic i_port_power_enable,
  // Port controls
  input wire logic o_power_switch_close,
  input wire logic o_discharge_en,
  input wire logic o_data_pulldown_en,
  input wire logic [8:0] o_profile_drive,
  input wire logic o_cc_limit,
  input wire logic o_no_handshake_flag
);
  localparam int DISCH = `DISCHARGE_TICKS * TICK_CYCLES;
  localparam int HLO = `RESET_HOLD_TICKS * TICK_CYCLES - 9;
  localparam int HHI = `RESET_HOLD_TICKS * TICK_CYCLES - 4;
  logic dce_ok;
  logic [15:0] disch_cnt_q;
  assign dce_ok = i_port_power_enable && i_emulation_enable && !i_mode_select_two;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      disch_cnt_q <= 16'h0000;
    end else if (o_discharge_en) begin
      disch_cnt_q <= disch_cnt_q + 16'h0001;
    end else begin
      disch_cnt_q <= 16'h0000;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // ****************************************
  // Emulation reset steps and port output rules
  // ****************************************
  sequence discharge_end_s;
    dce_ok [*3] ##0 $fell(o_discharge_en);
  endsequence
  sequence hold_then_close_s;
    !o_power_switch_close [*8] ##[HLO:HHI] o_power_switch_close;
  endsequence
  sequence pass_mode_s;
    (i_port_power_enable && !i_emulation_enable && i_mode_select_two) [*4];
  endsequence
  discharge_open_a: assert property (o_discharge_en |-> !o_power_switch_close)
    else $error("switch closed while discharging");
  discharge_len_a: assert property (discharge_end_s |-> (disch_cnt_q >= DISCH - 1 && disch_cnt_q <= DISCH + 1))
    else $error("discharge length wrong");
  hold_close_a: assert property (discharge_end_s |-> hold_then_close_s)
    else $error("reset hold time wrong");
  pulldown_reset_a: assert property (o_discharge_en |-> o_data_pulldown_en)
    else $error("pulldowns off during discharge");
  drive_powered_a: assert property (o_profile_drive != 9'h000 |-> o_power_switch_close && !o_discharge_en)
    else $error("profile applied without supply");
  drive_single_a: assert property ($onehot0(o_profile_drive))
    else $error("more than one profile applied");
  no_handshake_flag_sticky_a: assert property ((dce_ok && $stable({i_mode_select_one, i_port_power_enable})) [*4]
    ##0 o_no_handshake_flag |=> o_no_handshake_flag)
    else $error("no-handshake flag dropped");
  no_handshake_flag_clean_a: assert property (o_no_handshake_flag |-> o_profile_drive == 9'h000)
    else $error("signature left in no-handshake");
  pass_trip_a: assert property (pass_mode_s |-> o_power_switch_close && !o_cc_limit)
    else $error("pass-through limit mode wrong");
  power_abort_a: assert property (!i_port_power_enable [*3] |-> o_profile_drive == 9'h000)
    else $error("profile kept after power off");
endmodule
bind charge_cycle_sequencer charge_cycle_sequencer_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_mode_select_one(i_mode_select_one),
  .i_mode_select_two(i_mode_select_two), .i_emulation_enable(i_emulation_enable),
  .i_port_power_enable(i_port_power_enable), .o_power_switch_close(o_power_switch_close),
  .o_discharge_en(o_discharge_en), .o_data_pulldown_en(o_data_pulldown_en),
  .o_profile_drive(o_profile_drive), .o_cc_limit(o_cc_limit), .o_no_handshake_flag(o_no_handshake_flag));

// file: bench/charge_cycle_sequencer_test.sv
`timescale 1ns/1ps
module charge_cycle_sequencer_test;
  import charge_cycle_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic m_one = 1'b0, m_two = 1'b0, emu_en = 1'b1, port_power_enable = 1'b0;
  limit_code_t limit = 3'h3;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, cur;
  logic [8:0] drive, mask = 9'h002;
  logic sw_close, disch, pulldn, hs_close, cc, no_handshake_flag;
  int bad_count = 0;
  int n_tests = 0;
  logic [7:0] ra [10] = '{8'h12, 8'h16, 8'h25, 8'h40, 8'h51, 8'h17, 8'h18, 8'h30, 8'h41, 8'h7f};
  logic [7:0] re [10] = '{8'h00, 8'h07, 8'h00, 8'h04, 8'h00, 8'hff, 8'h10, 8'h0a, 8'h0a, 8'h00};
  always #2 clk_sys = ~clk_sys;
  charge_cycle_sequencer #(.TICK_CYCLES(4)) charge_cycle_sequencer_i (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_mode_select_one(m_one), .i_mode_select_two(m_two), .i_emulation_enable(emu_en),
    .i_port_power_enable(port_power_enable), .i_port_current(cur), .i_current_limit_setting(limit), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .o_power_switch_close(sw_close), .o_discharge_en(disch), .o_data_pulldown_en(pulldn),
    .o_profile_drive(drive), .o_hs_switch_close(hs_close), .o_cc_limit(cc), .o_no_handshake_flag(no_handshake_flag));
  portable_device_model portable_device_model_i (.i_switch_close(sw_close), .i_drive(drive),
    .i_accept_mask(mask), .o_current(cur));
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [9:0] e, input logic [9:0] s);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("register", 10'(e), 10'(reg_rdata & m));
  endtask
  task automatic wait_out(input logic [9:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      #1;
      if ({no_handshake_flag, drive} === v) return;
    end
    chk("wait outputs", v, {no_handshake_flag, drive});
    complete_run();
  endtask
  task automatic power(input logic p);
    @(posedge clk_sys);
    port_power_enable <= p;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int k = 0; k < 10; k++) rchk(ra[k], 8'hff, re[k]);
    wr(8'h12, 8'hff);
    rchk(8'h12, 8'hff, 8'h00);
    power(1'b1);
    wait_out(10'h001, 200);
    chk("cc", 10'h001, 10'(cc));
    wait_out(10'h002, 300);
    repeat (150) @(posedge clk_sys);
    rchk(8'h12, 8'hff, 8'h12);
    chk("drive", 10'h002, {no_handshake_flag, drive});
    chk("cc", 10'h001, 10'(cc));
    chk("hs", 10'h000, 10'(hs_close));
    power(1'b0);
    wr(8'h40, 8'h07);
    wr(8'h41, 8'h01);
    wr(8'h51, 8'h1c);
    mask <= 9'h100;
    power(1'b1);
    wait_out(10'h100, 80);
    repeat (30) @(posedge clk_sys);
    rchk(8'h12, 8'hff, 8'h82);
    chk("cc", 10'h001, 10'(cc));
    power(1'b0);
    wr(8'h40, 8'h04);
    wr(8'h16, 8'h01);
    wr(8'h25, 8'h02);
    limit <= 3'h5;
    mask <= 9'h000;
    power(1'b1);
    wait_out(10'h200, 4000);
    chk("hs", 10'h001, 10'(hs_close));
    chk("cc", 10'h000, 10'(cc));
    wr(8'h12, 8'h00);
    rchk(8'h12, 8'h03, 8'h01);
    power(1'b0);
    m_one <= 1'b1;
    wr(8'h16, 8'h03);
    wr(8'h17, 8'h01);
    power(1'b1);
    wait_out(10'h001, 200);
    wait_out(10'h000, 200);
    wait_out(10'h001, 200);
    mask <= 9'h001;
    repeat (50) @(posedge clk_sys);
    rchk(8'h12, 8'hff, 8'h02);
    chk("keep off", 10'h000, {no_handshake_flag, drive});
    @(posedge clk_sys);
    m_two <= 1'b1;
    emu_en <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk("pass-through", 10'h002, {drive, sw_close, cc});
    complete_run();
  end
endmodule
